// >>> hdl/pfc_top.sv
// protection fet gate control with avalon register slave
//
// Our own choices: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ns
module pfc_top import pfc_pkg::*; #(
  parameter int PREDISCHARGE_FET_GATE_CYC = PFC_PREDISCHARGE_FET_GATE_CYC,
  parameter int CUR_W = 16
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic [3:0] AVS_ADDRESS_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic [31:0] AVS_WRITEDATA_I,
  output logic [31:0] AVS_READDATA_O,
  output logic AVS_WAITREQUEST_O,
  input wire logic CHARGE_OFF_REQUEST_PIN_I,
  input wire logic DISCHARGE_OFF_REQUEST_PIN_I,
  input wire logic FAULT_CHG_I,
  input wire logic FAULT_DSG_I,
  input wire logic CELL_LOW_I,
  input wire logic [CUR_W-1:0] CURRENT_I,
  output logic CHARGE_FET_GATE_O,
  output logic DISCHARGE_FET_GATE_O,
  output logic PRECHARGE_FET_GATE_O,
  output logic PREDISCHARGE_FET_GATE_O,
  output logic OVERDRIVE_10V_O,
  output logic ALERT_O
);
  ////////////////////////////////////////////////////////////////////
  // pin, fault and cell low synchronisers
  logic cpin_s;
  logic dpin_s;
  logic fchg_s;
  logic fdsg_s;
  logic low_s;
  pfc_sync u_cpin (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .d_i(CHARGE_OFF_REQUEST_PIN_I), .q_o(cpin_s));
  pfc_sync u_dpin (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .d_i(DISCHARGE_OFF_REQUEST_PIN_I), .q_o(dpin_s));
  pfc_sync u_fchg (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .d_i(FAULT_CHG_I), .q_o(fchg_s));
  pfc_sync u_fdsg (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .d_i(FAULT_DSG_I), .q_o(fdsg_s));
  pfc_sync u_low (.CLOCK_I(CLOCK_I), .SYS_RST_I(SYS_RST_I),
    .d_i(CELL_LOW_I), .q_o(low_s));

  ////////////////////////////////////////////////////////////////////
  // registers
  logic [PFC_CTRL_W-1:0] ctrl_r;
  logic [PFC_CTRL_W-1:0] ctrl_nxt;
  logic [7:0] thr_r;
  logic [7:0] thr_nxt;
  logic hold_c_r;
  logic hold_c_nxt;
  logic hold_d_r;
  logic hold_d_nxt;
  logic flt_c_r;
  logic flt_c_nxt;
  logic flt_d_r;
  logic flt_d_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ack_r;
  logic ack_nxt;
  pfc_ds_t ds_r;
  pfc_ds_t ds_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic chg_r;
  logic chg_nxt;
  logic dsg_r;
  logic dsg_nxt;
  logic precharge_fet_gate_r;
  logic precharge_fet_gate_nxt;
  logic predischarge_fet_gate_r;
  logic predischarge_fet_gate_nxt;

  pfc_mode_t mode;
  logic wr_cmd;
  logic blk_c;
  logic blk_d;
  logic req_c;
  logic req_d;
  logic bd_c;
  logic bd_d;
  logic signed [CUR_W-1:0] cur;
  logic signed [CUR_W-1:0] thr_s;

  assign mode = pfc_mode_t'(ctrl_r[PFC_CTRL_MODE_LSB +: 2]);
  // commands act in the answer cycle, the edge where waitrequest is low
  assign wr_cmd = AVS_WRITE_I && ack_r && AVS_ADDRESS_I == PFC_CMD_OFF;
  assign cur = $signed(CURRENT_I);
  assign thr_s = $signed({{(CUR_W-8){1'b0}}, thr_r});

  ////////////////////////////////////////////////////////////////////
  // avalon slave: one wait cycle, answer on second cycle
  always_comb begin
    ctrl_nxt = ctrl_r;
    thr_nxt = thr_r;
    rdata_nxt = rdata_r;
    ack_nxt = 1'b0;
    if ((AVS_READ_I || AVS_WRITE_I) && !ack_r) begin
      ack_nxt = 1'b1;
      rdata_nxt = 32'h0000_0000;
      if (!AVS_WRITE_I) begin
        case (AVS_ADDRESS_I)
          PFC_CTRL_OFF: rdata_nxt = {23'h0, ctrl_r};
          PFC_STAT_OFF: rdata_nxt = {22'h0, ds_r, predischarge_fet_gate_r, precharge_fet_gate_r,
            dsg_r, chg_r, hold_d_r, hold_c_r, flt_d_r, flt_c_r};
          PFC_THR_OFF: rdata_nxt = {24'h0, thr_r};
          default: rdata_nxt = 32'h0000_0000;
        endcase
      end
    end
    // writes land only at the edge that ends the answer cycle
    if (AVS_WRITE_I && ack_r) begin
      if (AVS_ADDRESS_I == PFC_CTRL_OFF) begin
        ctrl_nxt = AVS_WRITEDATA_I[PFC_CTRL_W-1:0];
      end
      if (AVS_ADDRESS_I == PFC_THR_OFF) begin
        thr_nxt = AVS_WRITEDATA_I[7:0];
      end
    end
  end
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_r;
  assign AVS_READDATA_O = rdata_r;

  ////////////////////////////////////////////////////////////////////
  // host holds and sticky fault flags
  always_comb begin
    hold_c_nxt = hold_c_r;
    hold_d_nxt = hold_d_r;
    flt_c_nxt = flt_c_r;
    flt_d_nxt = flt_d_r;
    if (wr_cmd && mode != PFC_MODE_AUTO) begin
      if (AVS_WRITEDATA_I[PFC_CMD_RELEASE]) begin
        hold_c_nxt = 1'b0;
        hold_d_nxt = 1'b0;
      end
      if (AVS_WRITEDATA_I[PFC_CMD_CHG_OFF]) begin
        hold_c_nxt = 1'b1;
      end
      if (AVS_WRITEDATA_I[PFC_CMD_DSG_OFF]) begin
        hold_d_nxt = 1'b1;
      end
    end
    if (wr_cmd && AVS_WRITEDATA_I[PFC_CMD_FLT_CLR]) begin
      flt_c_nxt = 1'b0;
      flt_d_nxt = 1'b0;
    end
    if (fchg_s) begin
      flt_c_nxt = 1'b1;
    end
    if (fdsg_s) begin
      flt_d_nxt = 1'b1;
    end
  end
  assign ALERT_O = (mode == PFC_MODE_MAN) && (flt_c_r || flt_d_r);

  ////////////////////////////////////////////////////////////////////
  // block reasons; live faults let auto mode recover by itself
  always_comb begin
    blk_c = fchg_s || hold_c_r
      || (ctrl_r[PFC_CTRL_PIN_EN] && cpin_s);
    blk_d = fdsg_s || hold_d_r
      || (ctrl_r[PFC_CTRL_PIN_EN] && dpin_s);
    req_c = ctrl_r[PFC_CTRL_CHG_REQ];
    req_d = ctrl_r[PFC_CTRL_DSG_REQ];
    // charge FET body diode guard
    // judged on the unforced request, else the forced gate would toggle
    bd_c = !ctrl_r[PFC_CTRL_PARALLEL]
      && !(req_c && !blk_c && !(ctrl_r[PFC_CTRL_PRECHARGE_FET_GATE_EN] && low_s))
      && (dsg_r || predischarge_fet_gate_r) && (cur < -thr_s);
    bd_d = !ctrl_r[PFC_CTRL_PARALLEL] && (ds_r != PFC_DS_ON)
      && (chg_r || precharge_fet_gate_r) && (cur > thr_s);
  end

  ////////////////////////////////////////////////////////////////////
  // gate drive and predischarge sequence
  always_comb begin
    ds_nxt = ds_r;
    cnt_nxt = cnt_r;
    // gate is request and no block
    case (ds_r)
      PFC_DS_OFF: begin
        if (req_d && !blk_d) begin
          if (ctrl_r[PFC_CTRL_PREDISCHARGE_FET_GATE_EN]) begin
            ds_nxt = PFC_DS_PRE;
            cnt_nxt = 16'(PREDISCHARGE_FET_GATE_CYC - 1);
          end else begin
            ds_nxt = PFC_DS_ON;
          end
        end
      end
      PFC_DS_PRE: begin
        if (!req_d || blk_d) begin
          ds_nxt = PFC_DS_OFF;
        end else if (cnt_r == 16'h0000) begin
          ds_nxt = PFC_DS_ON;
        end else begin
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      PFC_DS_ON: begin
        if (!req_d || blk_d) begin
          ds_nxt = PFC_DS_OFF;
        end
      end
      default: ds_nxt = PFC_DS_OFF;
    endcase
    predischarge_fet_gate_nxt = ds_nxt == PFC_DS_PRE;
    dsg_nxt = ds_nxt == PFC_DS_ON || bd_d;
    // precharge path while cells are low
    chg_nxt = (req_c && !blk_c && !(ctrl_r[PFC_CTRL_PRECHARGE_FET_GATE_EN] && low_s))
      || bd_c;
    precharge_fet_gate_nxt = req_c && !blk_c && ctrl_r[PFC_CTRL_PRECHARGE_FET_GATE_EN] && low_s;
  end

  ////////////////////////////////////////////////////////////////////
  // state registers
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      ctrl_r <= PFC_CTRL_RST;
      thr_r <= PFC_THR_RST;
      hold_c_r <= 1'b0;
      hold_d_r <= 1'b0;
      flt_c_r <= 1'b0;
      flt_d_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ack_r <= 1'b0;
      ds_r <= PFC_DS_OFF;
      cnt_r <= 16'h0000;
      chg_r <= 1'b0;
      dsg_r <= 1'b0;
      precharge_fet_gate_r <= 1'b0;
      predischarge_fet_gate_r <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      hold_c_r <= hold_c_nxt;
      hold_d_r <= hold_d_nxt;
      flt_c_r <= flt_c_nxt;
      flt_d_r <= flt_d_nxt;
      rdata_r <= rdata_nxt;
      ack_r <= ack_nxt;
      ds_r <= ds_nxt;
      cnt_r <= cnt_nxt;
      chg_r <= chg_nxt;
      dsg_r <= dsg_nxt;
      precharge_fet_gate_r <= precharge_fet_gate_nxt;
      predischarge_fet_gate_r <= predischarge_fet_gate_nxt;
    end
  end

  assign CHARGE_FET_GATE_O = chg_r;
  assign DISCHARGE_FET_GATE_O = dsg_r;
  assign PRECHARGE_FET_GATE_O = precharge_fet_gate_r;
  assign PREDISCHARGE_FET_GATE_O = predischarge_fet_gate_r;
  assign OVERDRIVE_10V_O = ctrl_r[PFC_CTRL_OD10];
endmodule // pfc_top

// >>> hdl/pfc_pkg.sv
// package for the protection fet control block
//
// Overview of operation
// - config picks 7V or 10V gate overdrive
// - any fault turns charge/discharge gates off
// - autonomous mode recovers by itself after fault
// - outside auto mode, host off command holds FETs until release
// - asserted off pin blocks matching FET
// - pin release reenables only if unblocked
// - manual mode raises interrupt, status readable
// - release command or pin reenables if unblocked
// - low cell voltage charges through precharge FET
// - a charge fault turns precharge gate off
// - predischarge first, then discharge on, predischarge off
// - big discharge current turns charge FET on
// - charge FET off again when current subsides
// - big charge current turns discharge FET on
// - discharge FET off again when current subsides
// - body diode guard only in series configuration
// - off pins ORed with every other off reason
package pfc_pkg;
  // register byte offsets
  localparam logic [3:0] PFC_CTRL_OFF = 4'h0;
  localparam logic [3:0] PFC_CMD_OFF = 4'h4;
  localparam logic [3:0] PFC_STAT_OFF = 4'h8;
  localparam logic [3:0] PFC_THR_OFF = 4'hC;
  // control field positions
  localparam int PFC_CTRL_MODE_LSB = 0;
  localparam int PFC_CTRL_OD10 = 2;
  localparam int PFC_CTRL_PREDISCHARGE_FET_GATE_EN = 3;
  localparam int PFC_CTRL_PRECHARGE_FET_GATE_EN = 4;
  localparam int PFC_CTRL_PARALLEL = 5;
  localparam int PFC_CTRL_PIN_EN = 6;
  localparam int PFC_CTRL_CHG_REQ = 7;
  localparam int PFC_CTRL_DSG_REQ = 8;
  localparam int PFC_CTRL_W = 9;
  localparam logic [8:0] PFC_CTRL_RST = 9'h1_C8;
  // command bits: off, release and fault clear
  localparam int PFC_CMD_CHG_OFF = 0;
  localparam int PFC_CMD_DSG_OFF = 1;
  localparam int PFC_CMD_RELEASE = 2;
  localparam int PFC_CMD_FLT_CLR = 3;
  // predischarge dwell before the discharge FET turns on
  localparam int PFC_PREDISCHARGE_FET_GATE_TIME_US = 100;
  localparam int PFC_CLK_MHZ = 50;
  localparam int PFC_PREDISCHARGE_FET_GATE_CYC = PFC_PREDISCHARGE_FET_GATE_TIME_US * PFC_CLK_MHZ;
  localparam logic [7:0] PFC_THR_RST = 8'h10;
  typedef enum logic [1:0] {
    PFC_MODE_AUTO = 2'b00,
    PFC_MODE_PART = 2'b01,
    PFC_MODE_MAN = 2'b10
  } pfc_mode_t;
  typedef enum logic [1:0] {
    PFC_DS_OFF = 2'b00,
    PFC_DS_PRE = 2'b01,
    PFC_DS_ON = 2'b10
  } pfc_ds_t;
endpackage

// >>> hdl/pfc_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ns
module pfc_sync (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s1_nxt;
  logic s2_nxt;
  // first stage read only by the second
  always_comb begin
    s1_nxt = d_i;
    s2_nxt = s1_r;
  end
  always_ff @(posedge CLOCK_I) begin
    if (SYS_RST_I) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end
  assign q_o = s2_r;
endmodule // pfc_sync

// >>> tb/pfc_pack_model.sv
// behavioural pack: gates steer charger and load current
`timescale 1ns/1ns
module pfc_pack_model #(
  parameter int CUR_W = 16
) (
  input wire logic c_on_i,
  input wire logic d_on_i,
  input wire logic pc_on_i,
  input wire logic pd_on_i,
  input wire logic signed [CUR_W-1:0] charger_i,
  input wire logic signed [CUR_W-1:0] load_i,
  output logic [CUR_W-1:0] cur_o
);
  // body diodes pass current even with the series partner off
  assign cur_o = ((c_on_i | pc_on_i) ? charger_i : '0)
    + ((d_on_i | pd_on_i) ? load_i : '0);
endmodule // pfc_pack_model

// >>> tb/pfc_top_asserts.sv
// concurrent checks on the fet control ports
`timescale 1ns/1ns
module pfc_top_asserts #(
  parameter int PREDISCHARGE_FET_GATE_CYC = 4,
  parameter int CUR_W = 16
) (
  input wire logic CLOCK_I,
  input wire logic SYS_RST_I,
  input wire logic AVS_READ_I,
  input wire logic AVS_WRITE_I,
  input wire logic AVS_WAITREQUEST_O,
  input wire logic CHARGE_OFF_REQUEST_PIN_I,
  input wire logic DISCHARGE_OFF_REQUEST_PIN_I,
  input wire logic FAULT_CHG_I,
  input wire logic FAULT_DSG_I,
  input wire logic [CUR_W-1:0] CURRENT_I,
  input wire logic CHARGE_FET_GATE_O,
  input wire logic DISCHARGE_FET_GATE_O,
  input wire logic PRECHARGE_FET_GATE_O,
  input wire logic PREDISCHARGE_FET_GATE_O
);
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);
  logic req;
  logic calm;
  // current zero keeps body diode forcing out of the picture
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign calm = !FAULT_DSG_I && !DISCHARGE_OFF_REQUEST_PIN_I
    && CURRENT_I == '0;
  // predischarge dwell, then the main fet takes over
  sequence pre_s;
    PREDISCHARGE_FET_GATE_O [*4];
  endsequence
  sequence on_s;
    DISCHARGE_FET_GATE_O && !PREDISCHARGE_FET_GATE_O;
  endsequence
  ////////////////////////////////////////////////////////////////////
  flt_c_off_a:
  assert property ((FAULT_CHG_I && CURRENT_I == '0) [*5]
    |-> !CHARGE_FET_GATE_O && !PRECHARGE_FET_GATE_O)
    else $error("charge side on in fault");
  flt_d_off_a:
  assert property ((FAULT_DSG_I && CURRENT_I == '0) [*5]
    |-> !DISCHARGE_FET_GATE_O && !PREDISCHARGE_FET_GATE_O)
    else $error("discharge side on in fault");
  cpin_block_a:
  assert property ((CHARGE_OFF_REQUEST_PIN_I && CURRENT_I == '0) [*5]
    |-> !CHARGE_FET_GATE_O)
    else $error("charge on with pin held");
  dpin_block_a:
  assert property ((DISCHARGE_OFF_REQUEST_PIN_I && CURRENT_I == '0) [*5]
    |-> !DISCHARGE_FET_GATE_O)
    else $error("discharge on with pin held");
  pre_order_a:
  assert property ($rose(PREDISCHARGE_FET_GATE_O)
    |-> (pre_s ##1 on_s) or (##[0:4] !calm))
    else $error("predischarge order broken");
  dsg_via_pre_a:
  assert property ($rose(DISCHARGE_FET_GATE_O) && calm
    |-> $past(PREDISCHARGE_FET_GATE_O))
    else $error("discharge on without predischarge");
  wait_two_a:
  assert property ($rose(req) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("access not answered in two cycles");
  idle_nowait_a:
  assert property (!req |-> !AVS_WAITREQUEST_O)
    else $error("waitrequest while idle");
  rst_gates_a:
  assert property ($fell(SYS_RST_I) |-> !CHARGE_FET_GATE_O
    && !DISCHARGE_FET_GATE_O && !PREDISCHARGE_FET_GATE_O)
    else $error("gate on straight after reset");
endmodule // pfc_top_asserts
////////////////////////////////////////////////////////////////////////
bind pfc_top pfc_top_asserts #(.PREDISCHARGE_FET_GATE_CYC(PREDISCHARGE_FET_GATE_CYC), .CUR_W(CUR_W)) chk_u (
  .CLOCK_I, .SYS_RST_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_WAITREQUEST_O,
  .CHARGE_OFF_REQUEST_PIN_I, .DISCHARGE_OFF_REQUEST_PIN_I, .FAULT_CHG_I,
  .FAULT_DSG_I, .CURRENT_I, .CHARGE_FET_GATE_O, .DISCHARGE_FET_GATE_O,
  .PRECHARGE_FET_GATE_O, .PREDISCHARGE_FET_GATE_O);

// >>> tb/protection_fet_control_tb_top.sv
// self-checking bench for the protection fet control block
`timescale 1ns/1ns
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin \
  num_errors++; $display("ERROR %s exp %0h got %0h", n, e, a); end end
module protection_fet_control_tb_top import pfc_pkg::*; ;
  logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, cpin = 1'b0;
  logic dpin = 1'b0, fc = 1'b0, fd = 1'b0, low = 1'b0;
  logic [3:0] addr = '0;
  logic [31:0] wdata = '0, rdata, q;
  logic signed [15:0] charger = '0, load = '0;
  logic [15:0] cur;
  logic waitreq, g_c, g_d, g_pc, g_pd, od, alert;
  int num_errors = 0, checks_done = 0;
  pfc_top #(.PREDISCHARGE_FET_GATE_CYC(4), .CUR_W(16)) dut_u (.CLOCK_I(clk),
    .SYS_RST_I(rst), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd),
    .AVS_WRITE_I(wr), .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(waitreq), .CHARGE_OFF_REQUEST_PIN_I(cpin),
    .DISCHARGE_OFF_REQUEST_PIN_I(dpin), .FAULT_CHG_I(fc),
    .FAULT_DSG_I(fd), .CELL_LOW_I(low), .CURRENT_I(cur),
    .CHARGE_FET_GATE_O(g_c), .DISCHARGE_FET_GATE_O(g_d),
    .PRECHARGE_FET_GATE_O(g_pc), .PREDISCHARGE_FET_GATE_O(g_pd),
    .OVERDRIVE_10V_O(od), .ALERT_O(alert));
  pfc_pack_model #(.CUR_W(16)) pack_u (.c_on_i(g_c), .d_on_i(g_d),
    .pc_on_i(g_pc), .pd_on_i(g_pd), .charger_i(charger), .load_i(load),
    .cur_o(cur));
  // free running clock, 20 ns period
  initial forever #10 clk = ~clk;
  ////////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // one access; extra idle edge so strobes never rise in the same step
  task automatic bus(input logic w, input logic [3:0] a,
    input logic [31:0] d);
    int n;
    n = 0;
    addr <= a;
    wr <= w;
    rd <= !w;
    wdata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
    if (n >= 50) begin
      num_errors++;
      conclude();
    end
  endtask
  task automatic ctl(input logic [8:0] v);
    bus(1'b1, PFC_CTRL_OFF, {23'h0, v});
  endtask
  ////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    bus(1'b0, PFC_CTRL_OFF, '0);
    `CHK("ctrl reset", 32'h0000_01C8, q)
    bus(1'b0, PFC_THR_OFF, '0);
    `CHK("thr reset", 32'h0000_0010, q)
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, '0);
    `CHK("unmapped", 32'h0000_0000, q)
    `CHK("charge on", 1'b1, g_c)
    `CHK("discharge on", 1'b1, g_d)
    ctl(PFC_CTRL_RST | 9'h004);
    `CHK("od 10v", 1'b1, od)
    ctl(PFC_CTRL_RST);
    `CHK("od 7v", 1'b0, od)
    $display("done regs");
  endtask
  task automatic t_fault();
    fc <= 1'b1;
    fd <= 1'b1;
    cyc(6);
    `CHK("charge flt", 1'b0, g_c)
    `CHK("discharge flt", 1'b0, g_d)
    fc <= 1'b0;
    fd <= 1'b0;
    cyc(5);
    `CHK("pre first", 1'b1, g_pd)
    `CHK("dis later", 1'b0, g_d)
    cyc(6);
    `CHK("charge back", 1'b1, g_c)
    `CHK("dis back", 1'b1, g_d)
    `CHK("pre off", 1'b0, g_pd)
    $display("done fault");
  endtask
  task automatic t_pins();
    cpin <= 1'b1;
    dpin <= 1'b1;
    cyc(6);
    `CHK("cpin off", 1'b0, g_c)
    `CHK("dpin off", 1'b0, g_d)
    cpin <= 1'b0;
    fc <= 1'b1;
    cyc(6);
    `CHK("fault holds", 1'b0, g_c)
    fc <= 1'b0;
    cyc(6);
    `CHK("charge free", 1'b1, g_c)
    `CHK("other pin", 1'b0, g_d)
    dpin <= 1'b0;
    cyc(12);
    `CHK("dis free", 1'b1, g_d)
    $display("done pins");
  endtask
  task automatic t_hold();
    ctl(PFC_CTRL_RST | 9'h001);
    fc <= 1'b1;
    cyc(6);
    bus(1'b1, PFC_CMD_OFF, 32'h0000_0001);
    fc <= 1'b0;
    cyc(8);
    `CHK("held off", 1'b0, g_c)
    bus(1'b1, PFC_CMD_OFF, 32'h0000_0004);
    cyc(4);
    `CHK("released", 1'b1, g_c)
    ctl(PFC_CTRL_RST | 9'h002);
    fd <= 1'b1;
    cyc(6);
    `CHK("alert", 1'b1, alert)
    bus(1'b0, PFC_STAT_OFF, '0);
    `CHK("flag", 1'b1, q[1])
    fd <= 1'b0;
    bus(1'b1, PFC_CMD_OFF, 32'h0000_0002);
    cyc(8);
    `CHK("cmd off", 1'b0, g_d)
    bus(1'b1, PFC_CMD_OFF, 32'h0000_000C);
    cyc(12);
    `CHK("alert clr", 1'b0, alert)
    `CHK("dis again", 1'b1, g_d)
    $display("done hold");
  endtask
  task automatic t_pre();
    ctl(PFC_CTRL_RST | 9'h010);
    low <= 1'b1;
    cyc(6);
    `CHK("pre path", 1'b1, g_pc)
    `CHK("main off", 1'b0, g_c)
    fc <= 1'b1;
    cyc(6);
    `CHK("pre flt", 1'b0, g_pc)
    fc <= 1'b0;
    low <= 1'b0;
    cyc(6);
    `CHK("main back", 1'b1, g_c)
    $display("done precharge");
  endtask
  task automatic t_diode();
    ctl(PFC_CTRL_RST);
    cpin <= 1'b1;
    cyc(6);
    load <= -16'sd100;
    cyc(6);
    `CHK("diode c on", 1'b1, g_c)
    load <= '0;
    cyc(6);
    `CHK("diode c off", 1'b0, g_c)
    ctl(PFC_CTRL_RST | 9'h020);
    load <= -16'sd100;
    cyc(6);
    `CHK("parallel", 1'b0, g_c)
    load <= '0;
    cpin <= 1'b0;
    ctl(PFC_CTRL_RST);
    dpin <= 1'b1;
    cyc(6);
    charger <= 16'sd100;
    cyc(6);
    `CHK("diode d on", 1'b1, g_d)
    charger <= '0;
    cyc(6);
    `CHK("diode d off", 1'b0, g_d)
    dpin <= 1'b0;
    cyc(12);
    $display("done diode");
  endtask
  ////////////////////////////////////////////////////////////////////
  // main sequence after a five cycle reset
  initial begin
    cyc(5);
    rst <= 1'b0;
    cyc(12);
    t_regs();
    t_fault();
    t_pins();
    t_hold();
    t_pre();
    t_diode();
    conclude();
  end
endmodule // protection_fet_control_tb_top
